// ---- bench/les_far_end.sv ----
`timescale 1ns/100ps
// Far end of the link: raises one event line per request, idle lines low except line 14, which follows lock_lost_i
module les_far_end (
    input  wire logic        ev_vld_i,
    input  wire logic [3:0]  ev_code_i,
    input  wire logic        lock_lost_i,
    output logic      [15:0] ev_o
);
    // One-hot event pulse; PLL state is a level of its own
    always_comb begin
        ev_o = 16'h0000;
        if (ev_vld_i) begin
            ev_o[ev_code_i] = 1'b1;
        end
        ev_o[14] = lock_lost_i;
    end
endmodule

// ---- bench/les_link_error_status_test.sv ----
`timescale 1ns/100ps
module les_link_error_status_test;
    localparam logic [18:0] ERR = 19'h41000;
    localparam int          HBF = 20;
    localparam int          HBS = 40;
    logic        clk_i;
    logic        arst_n_i;
    logic        wr, rd, lrst, hbsel, vld, lost, push, rclr, tclr;
    logic        rxs, txs, drop, blk, ok, onl, e_ok, e_rx, e_tx;
    logic [3:0]  code;
    logic [18:0] addr;
    logic [31:0] wdata, rdata, exp;
    logic [5:0]  src;
    logic [15:0] ev;
    logic [7:0]  lf;
    logic [31:0] ebits [16];
    logic [3:0]  eflg [16];
    int          num_errors, checks, n, lim;

    les_link_error_status #(
        .HB_FAST_CYCLES(32'(HBF)),
        .HB_SLOW_CYCLES(32'(HBS))
    ) DUT (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .link_reset_i(lrst), .hb_select_i(hbsel), .tx_xact_i(ev[15]),
        .tx_pkt_err_i(ev[0]), .rx_push_i(ev[1] | push), .rx_fifo_full_i(ev[1]),
        .rx_path_err_i(ev[2]), .rx_body_err_i(ev[12]), .rx_head_err_i(ev[13]),
        .src_node_i(src), .ack_drop_i(ev[3]), .ctl_pkt_err_i(ev[4]),
        .rx_eop_timeout_i(ev[5]), .tx_supp_timeout_i(ev[6]), .ctl_hb_fail_i(ev[7]),
        .rx_flow_fault_i(ev[8]), .pll_unlock_i(ev[14]), .tx_fifo_full_i(ev[9]),
        .tx_malformed_i(ev[10]), .remote_rx_err_i(ev[11]), .rx_sum_clr_i(rclr),
        .tx_sum_clr_i(tclr), .rx_summary_o(rxs), .tx_summary_o(txs),
        .rx_pkt_drop_o(drop), .tx_pkt_block_o(blk), .link_ok_o(ok), .link_online_o(onl)
    );
    les_far_end far (.ev_vld_i(vld), .ev_code_i(code), .lock_lost_i(lost), .ev_o(ev));

    // Free-running clock
    initial begin
        clk_i = 1'b0;
        forever begin
            #2.5 clk_i = ~clk_i;
        end
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk32(input logic [31:0] got, input logic [31:0] want, input string what);
        checks++;
        if (got !== want) begin
            num_errors++;
            $display("ERROR %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic chk1(input logic got, input logic want, input string what);
        checks++;
        if (got !== want) begin
            num_errors++;
            $display("ERROR %0t %s got %b want %b", $time, what, got, want);
        end
    endtask

    task automatic final_report();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Inputs move at the falling edge only
    task automatic step(input int k);
        repeat (k) begin
            @(posedge clk_i);
            @(negedge clk_i);
        end
    endtask

    task automatic wr_reg(input logic [18:0] a, input logic [31:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        if (a == ERR) begin
            exp = exp & ~(d & 32'h7610_0000);
            exp = (exp & ~32'h0043_0000) | (d & 32'h0043_0000);
        end
        step(1); // Idle cycle before the next strobe
    endtask

    task automatic rd_reg(input logic [18:0] a, input logic [31:0] want);
        addr = a;
        rd = 1'b1;
        step(1);
        rd = 1'b0;
        chk32(rdata, want, "register read");
        step(1); // Idle cycle before the next strobe
    endtask

    task automatic pulse(input int c);
        code = 4'(c);
        src = lf[5:0];
        push = lf[7];
        lf = lfsr(lf);
        vld = 1'b1;
        step(1);
        vld = 1'b0;
    endtask

    // One event, then its effects one and two cycles later
    task automatic fire(input int c);
        pulse(c);
        exp = exp | ebits[c];
        if (c inside {2, 12, 13}) exp[15:10] = src;
        if (ebits[c][18]) e_ok = 1'b0;
        e_rx = e_rx | eflg[c][3];
        e_tx = e_tx | eflg[c][2];
        chk1(rxs, e_rx, "rx summary");
        chk1(txs, e_tx, "tx summary");
        chk1(ok, e_ok, "link ok");
        chk1(drop, eflg[c][1], "drop");
        chk1(blk, eflg[c][0], "block");
        step(1);
        chk1(onl, e_ok, "online");
        rd_reg(ERR, exp);
    endtask

    // Zero write keeps flags, then clear everything and reset the link
    task automatic clean();
        wr_reg(ERR, 32'h0000_0000);
        rd_reg(ERR, exp);
        wr_reg(ERR, 32'h7610_0000);
        rclr = 1'b1;
        tclr = 1'b1;
        step(1);
        rclr = 1'b0;
        tclr = 1'b0;
        e_rx = 1'b0;
        e_tx = 1'b0;
        chk1(rxs, 1'b0, "rx clear");
        chk1(txs, 1'b0, "tx clear");
        lrst = 1'b1;
        step(1);
        lrst = 1'b0;
        exp = exp & ~32'h0004_ffff;
        e_ok = 1'b1;
        step(1);
        chk1(ok, 1'b1, "ok after reset");
        chk1(onl, 1'b1, "online after reset");
        rd_reg(ERR, exp);
    endtask

    initial begin
        {wr, rd, lrst, hbsel, vld, lost, push, rclr, tclr, arst_n_i} = '0;
        {code, addr, wdata, src, exp, e_rx, e_tx} = '0;
        e_ok = 1'b1;
        lf = 8'h20;
        num_errors = 0;
        checks = 0;
        ebits = '{32'h1000_0000, 32'h4404_0000, 32'h0200_0000, 32'h0010_0000,
                  32'h0000_0200, 32'h4004_0100, 32'h4004_0080, 32'h4004_0040,
                  32'h4004_0020, 32'h4004_0008, 32'h1000_0008, 32'h1000_0004,
                  32'h0200_0002, 32'h0200_0001, 32'h0, 32'h0};
        eflg = '{4'h4, 4'hc, 4'ha, 4'h0, 4'h0, 4'he, 4'hc, 4'hc,
                 4'hc, 4'hd, 4'h5, 4'h4, 4'ha, 4'ha, 4'h0, 4'h0};
        step(5);
        arst_n_i = 1'b1;
        chk1(ok, 1'b1, "ok at reset");
        rd_reg(ERR, exp);
        wr_reg(ERR, 32'hfffd_ffff);
        wr_reg(19'h41004, 32'hffff_ffff);
        rd_reg(19'h41004, 32'h0000_0000);
        rd_reg(ERR, exp);
        for (int c = 0; c < 14; c++) begin
            fire(c);
            clean();
        end
        // PLL loss: live status bit plus the fatal response
        lost = 1'b1;
        step(6);
        exp = exp | 32'h4004_0010;
        e_ok = 1'b0;
        e_rx = 1'b1;
        e_tx = 1'b1;
        chk1(ok, 1'b0, "pll fatal");
        rd_reg(ERR, exp);
        lost = 1'b0;
        step(6);
        exp[4] = 1'b0;
        rd_reg(ERR, exp);
        clean();
        // Heartbeat: kept alive by traffic, then left idle
        for (int s = 0; s < 2; s++) begin
            lim = s ? HBF : HBS;
            hbsel = s[0];
            wr_reg(ERR, 32'h0002_0000);
            repeat (4) begin
                step(lim / 2);
                pulse(15);
            end
            chk1(ok, 1'b1, "kept alive");
            n = 0;
            while (ok === 1'b1 && n < 200) begin
                step(1);
                n++;
            end
            chk1(n >= lim - 2 && n <= lim + 3, 1'b1, "hb period");
            if (n == 200) final_report();
            exp = exp | 32'h6004_0000;
            e_ok = 1'b0;
            e_rx = 1'b1;
            e_tx = 1'b1;
            step(1);
            chk1(onl, 1'b0, "hb offline");
            rd_reg(ERR, exp);
            clean();
        end
        final_report();
    end
endmodule

// ---- design/les_link_error_status.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - Fatal path error on either direction sets summary bit 30; write one clears it.
// - Heartbeat expiry sets bit 29, both summaries, drops link OK then online.
// - Packet error on outgoing transmit write sets bit 28.
// - Push into full receive FIFO sets bit 26, both summaries, fatal shutdown.
// - Receive path error sets bit 25, receive summary; packet marked bad, dropped.
// - Dropped acknowledge sets clearable status bit 20 so software may retry.
// - Any fatal error sets read-only bit 18 and goes offline until reset.
// - With bit 17 set, no transmit within heartbeat period forces port offline.
// - Heartbeat period is 1.7 to 2 s when selected, else 7.4 to 8 s.
// - Bits 15:10 capture source node of a packet with receive path error.
// - Self-recovered control packet error sets bit 9 only; reset clears it.
// - Over-long packet sets bit 8, is filtered, fatal: summaries, 30, 18, offline.
// - Remote flow control failure sets bit 7 with full fatal response.
// - Control packet facility failure sets bit 6 with full fatal response.
// - Local receive flow fault sets bit 5, summaries, bit 30 and fatal flag.
// - Bit 4 shows live PLL unlock; unlock causes full fatal response.
// - Transmit FIFO full is fatal; malformed packet sets 28; packet never sent.
// - Loopback error reflected from peer sets bit 2, bit 28, transmit summary.
// - Body error sets bit 1, header error bit 0; each sets 25, receive summary.
// - Clearable bits clear only where a one is written.
// - Receive summary sets on any receive path error; rx_sum_clr_i clears.
module les_link_error_status #(
    parameter logic [31:0] HB_FAST_CYCLES = les_pkg::HB_FAST_CYC,
    parameter logic [31:0] HB_SLOW_CYCLES = les_pkg::HB_SLOW_CYC
) (
    input  wire logic                       clk_i,
    input  wire logic                       arst_n_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    input  wire logic [les_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [31:0]                reg_wdata_i,
    output logic      [31:0]                reg_rdata_o,
    input  wire logic                       link_reset_i,
    input  wire logic                       hb_select_i,
    input  wire logic                       tx_xact_i,
    input  wire logic                       tx_pkt_err_i,
    input  wire logic                       rx_push_i,
    input  wire logic                       rx_fifo_full_i,
    input  wire logic                       rx_path_err_i,
    input  wire logic                       rx_body_err_i,
    input  wire logic                       rx_head_err_i,
    input  wire logic [les_pkg::SRC_W-1:0]  src_node_i,
    input  wire logic                       ack_drop_i,
    input  wire logic                       ctl_pkt_err_i,
    input  wire logic                       rx_eop_timeout_i,
    input  wire logic                       tx_supp_timeout_i,
    input  wire logic                       ctl_hb_fail_i,
    input  wire logic                       rx_flow_fault_i,
    input  wire logic                       pll_unlock_i,
    input  wire logic                       tx_fifo_full_i,
    input  wire logic                       tx_malformed_i,
    input  wire logic                       remote_rx_err_i,
    input  wire logic                       rx_sum_clr_i,
    input  wire logic                       tx_sum_clr_i,
    output logic                            rx_summary_o,
    output logic                            tx_summary_o,
    output logic                            rx_pkt_drop_o,
    output logic                            tx_pkt_block_o,
    output logic                            link_ok_o,
    output logic                            link_online_o
);

    typedef enum logic [1:0] {LES_RUN, LES_DROP_OK, LES_OFFLINE} les_link_st_t;

    les_link_st_t state;
    les_link_st_t next_state;
    logic [31:0]  err;
    logic [31:0]  next_err;
    logic [31:0]  next_rdata;
    logic [31:0]  hb_cnt;
    logic [31:0]  next_hb_cnt;
    logic [31:0]  hb_limit;
    logic         pll_meta;
    logic         pll_s;
    logic         next_rx_sum;
    logic         next_tx_sum;
    logic         next_rx_drop;
    logic         next_tx_block;
    logic         next_link_ok;
    logic         next_link_online;
    logic         reg_hit;
    logic         hb_fire;
    logic         rx_ovf;
    logic         fatal_evt;
    logic         rx_evt;
    logic         tx_pkt_evt;

    // Two-stage synchroniser for the PLL lock pin
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pll_meta <= 1'b0;
            pll_s    <= 1'b0;
        end else begin
            pll_meta <= pll_unlock_i;
            pll_s    <= pll_meta;
        end
    end

    // Event decode
    always_comb begin
        reg_hit    = (reg_addr_i == les_pkg::ERR_OFFSET);
        hb_limit   = hb_select_i ? HB_FAST_CYCLES : HB_SLOW_CYCLES;
        hb_fire    = err[les_pkg::B_HB_ENABLE] && (state == LES_RUN)
                     && !tx_xact_i && (hb_cnt == hb_limit - les_pkg::HB_CNT_ONE);
        rx_ovf     = rx_push_i && rx_fifo_full_i;
        fatal_evt  = hb_fire | rx_ovf | rx_eop_timeout_i | tx_supp_timeout_i
                     | ctl_hb_fail_i | rx_flow_fault_i | pll_s | tx_fifo_full_i;
        rx_evt     = rx_path_err_i | rx_body_err_i | rx_head_err_i;
        tx_pkt_evt = tx_pkt_err_i | tx_malformed_i | remote_rx_err_i;
    end

    // Heartbeat counter: restarts on every transmit transaction
    always_comb begin
        if (!err[les_pkg::B_HB_ENABLE] || state != LES_RUN || tx_xact_i || hb_fire) begin
            next_hb_cnt = '0;
        end else begin
            next_hb_cnt = hb_cnt + les_pkg::HB_CNT_ONE;
        end
    end

    // Error register: clears first, then events, so a set wins
    always_comb begin
        next_err = err;
        if (reg_wr_i && reg_hit) begin
            next_err = next_err & ~(reg_wdata_i & les_pkg::W1C_MASK);
            next_err = (next_err & ~les_pkg::RW_MASK) | (reg_wdata_i & les_pkg::RW_MASK);
        end
        if (link_reset_i) begin
            next_err = next_err & ~les_pkg::LINK_CLR_MASK;
        end
        if (fatal_evt) begin
            next_err[les_pkg::B_FATAL_SUM] = 1'b1;
            next_err[les_pkg::B_FATAL]     = 1'b1;
        end
        if (hb_fire)           next_err[les_pkg::B_HB_EXPIRED]  = 1'b1;
        if (tx_pkt_evt)        next_err[les_pkg::B_TX_PKT_ERR]  = 1'b1;
        if (rx_ovf)            next_err[les_pkg::B_RX_FIFO_OVF] = 1'b1;
        if (rx_evt)            next_err[les_pkg::B_RX_PKT_ERR]  = 1'b1;
        if (ack_drop_i)        next_err[les_pkg::B_ACK_DROP]    = 1'b1;
        if (ctl_pkt_err_i)     next_err[les_pkg::B_CTL_HIST]    = 1'b1;
        if (rx_eop_timeout_i)  next_err[les_pkg::B_RX_EOP_TO]   = 1'b1;
        if (tx_supp_timeout_i) next_err[les_pkg::B_TX_SUPP_TO]  = 1'b1;
        if (ctl_hb_fail_i)     next_err[les_pkg::B_CTL_HB]      = 1'b1;
        if (rx_flow_fault_i)   next_err[les_pkg::B_RX_FLOW]     = 1'b1;
        if (tx_fifo_full_i || tx_malformed_i) begin
            next_err[les_pkg::B_TX_ERR] = 1'b1;
        end
        if (remote_rx_err_i)   next_err[les_pkg::B_REMOTE_RX]   = 1'b1;
        if (rx_body_err_i)     next_err[les_pkg::B_RX_BODY]     = 1'b1;
        if (rx_head_err_i)     next_err[les_pkg::B_RX_HEAD]     = 1'b1;
        if (rx_evt) begin
            next_err[les_pkg::B_SRC_LO +: les_pkg::SRC_W] = src_node_i;
        end
        next_err[les_pkg::B_PLL_UNLOCK] = pll_s;
    end

    // Path summaries, set wins over clear
    always_comb begin
        next_rx_sum = (rx_summary_o && !rx_sum_clr_i) || rx_evt || fatal_evt;
        next_tx_sum = (tx_summary_o && !tx_sum_clr_i) || tx_pkt_evt || fatal_evt;
        next_rx_drop  = rx_evt || rx_eop_timeout_i;
        next_tx_block = tx_malformed_i || tx_fifo_full_i;
        next_rdata    = (reg_rd_i && reg_hit) ? err : '0;
    end

    // Fatal link error sequence: link OK falls, then link online
    always_comb begin
        next_state = state;
        unique case (state)
            LES_RUN: begin
                if (fatal_evt) begin
                    next_state = LES_DROP_OK;
                end
            end
            LES_DROP_OK: begin
                next_state = LES_OFFLINE;
            end
            LES_OFFLINE: begin
                next_state = LES_OFFLINE;
            end
        endcase
        if (link_reset_i) begin
            next_state = LES_RUN;
        end
        next_link_ok     = (next_state == LES_RUN);
        next_link_online = (next_state != LES_OFFLINE);
    end

    // State registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state          <= LES_RUN;
            err            <= les_pkg::ERR_RESET;
            hb_cnt         <= '0;
            rx_summary_o   <= 1'b0;
            tx_summary_o   <= 1'b0;
            rx_pkt_drop_o  <= 1'b0;
            tx_pkt_block_o <= 1'b0;
            reg_rdata_o    <= '0;
            link_ok_o      <= 1'b1;
            link_online_o  <= 1'b1;
        end else begin
            state          <= next_state;
            err            <= next_err;
            hb_cnt         <= next_hb_cnt;
            rx_summary_o   <= next_rx_sum;
            tx_summary_o   <= next_tx_sum;
            rx_pkt_drop_o  <= next_rx_drop;
            tx_pkt_block_o <= next_tx_block;
            reg_rdata_o    <= next_rdata;
            link_ok_o      <= next_link_ok;
            link_online_o  <= next_link_online;
        end
    end

    // Checks
    default clocking les_cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    chk_fatal_sum_set: assert property (
        fatal_evt |=> err[les_pkg::B_FATAL_SUM] && err[les_pkg::B_FATAL]
    ) else $error("fatal event did not set summary and fatal bits");

    chk_hb_expiry_resp: assert property (
        hb_fire && !link_reset_i |=> err[les_pkg::B_HB_EXPIRED] && rx_summary_o
            && tx_summary_o && !link_ok_o ##1 !link_online_o
    ) else $error("heartbeat expiry response wrong");

    chk_ok_then_online: assert property (
        state == LES_RUN && fatal_evt && !link_reset_i ##1 !link_reset_i
            |-> !link_ok_o && link_online_o ##1 !link_online_o
    ) else $error("link OK and online did not fall in order");

    chk_tx_pkt_err: assert property (
        tx_pkt_err_i |=> err[les_pkg::B_TX_PKT_ERR] && tx_summary_o
    ) else $error("transmit packet error not logged");

    chk_rx_ovf_bit: assert property (
        rx_push_i && rx_fifo_full_i |=> err[les_pkg::B_RX_FIFO_OVF] && rx_summary_o
    ) else $error("receive FIFO overflow not logged");

    chk_rx_pkt_drop: assert property (
        rx_path_err_i |=> err[les_pkg::B_RX_PKT_ERR] && rx_pkt_drop_o && rx_summary_o
    ) else $error("bad receive packet not dropped");

    chk_src_capture: assert property (
        rx_path_err_i |=> err[les_pkg::B_SRC_LO +: les_pkg::SRC_W] == $past(src_node_i)
    ) else $error("source node not captured");

    chk_w1c_zero_keep: assert property (
        reg_wr_i && reg_hit && !reg_wdata_i[les_pkg::B_ACK_DROP]
            && err[les_pkg::B_ACK_DROP] |=> err[les_pkg::B_ACK_DROP]
    ) else $error("clearable bit lost on zero write");

    chk_ack_drop_set: assert property (
        ack_drop_i |=> err[les_pkg::B_ACK_DROP]
    ) else $error("dropped acknowledge not logged");

    chk_fatal_sticky: assert property (
        err[les_pkg::B_FATAL] && !link_reset_i |=> err[les_pkg::B_FATAL]
    ) else $error("fatal bit cleared without link reset");

    chk_offline_hold: assert property (
        state == LES_OFFLINE && !link_reset_i |=> !link_ok_o && !link_online_o
    ) else $error("link came back without reset");

    chk_hb_bound: assert property (
        hb_cnt < hb_limit || !err[les_pkg::B_HB_ENABLE] || state != LES_RUN
    ) else $error("heartbeat counter passed its period");

    chk_pll_live: assert property (
        !link_reset_i [*3] |-> err[les_pkg::B_PLL_UNLOCK] == $past(pll_unlock_i, 3)
    ) else $error("PLL status bit does not follow the pin");

    chk_tx_block: assert property (
        tx_malformed_i |=> tx_pkt_block_o && err[les_pkg::B_TX_ERR] && tx_summary_o
    ) else $error("malformed packet not blocked");

    chk_remote_err: assert property (
        remote_rx_err_i |=> err[les_pkg::B_REMOTE_RX] && err[les_pkg::B_TX_PKT_ERR]
    ) else $error("reflected loopback error not logged");

    chk_rx_sum_clear: assert property (
        rx_sum_clr_i && !rx_evt && !fatal_evt |=> !rx_summary_o
    ) else $error("receive summary did not clear");

endmodule

// ---- inc/les_pkg.sv ----
package les_pkg;

    // Register access port
    localparam int          ADDR_W        = 19;
    localparam logic [18:0] ERR_OFFSET    = 19'h41000;
    localparam logic [31:0] ERR_RESET     = 32'h0000_0000;

    // Field positions of the error status register
    localparam int B_FATAL_SUM    = 30;
    localparam int B_HB_EXPIRED   = 29;
    localparam int B_TX_PKT_ERR   = 28;
    localparam int B_RX_FIFO_OVF  = 26;
    localparam int B_RX_PKT_ERR   = 25;
    localparam int B_RSV_RW22     = 22;
    localparam int B_ACK_DROP     = 20;
    localparam int B_FATAL        = 18;
    localparam int B_HB_ENABLE    = 17;
    localparam int B_RSV_RW16     = 16;
    localparam int B_SRC_LO       = 10;
    localparam int SRC_W          = 6;
    localparam int B_CTL_HIST     = 9;
    localparam int B_RX_EOP_TO    = 8;
    localparam int B_TX_SUPP_TO   = 7;
    localparam int B_CTL_HB       = 6;
    localparam int B_RX_FLOW      = 5;
    localparam int B_PLL_UNLOCK   = 4;
    localparam int B_TX_ERR       = 3;
    localparam int B_REMOTE_RX    = 2;
    localparam int B_RX_BODY      = 1;
    localparam int B_RX_HEAD      = 0;

    // Bit groups by access type
    localparam logic [31:0] W1C_MASK      = 32'h7610_0000;
    localparam logic [31:0] RW_MASK       = 32'h0043_0000;
    localparam logic [31:0] LINK_CLR_MASK = 32'h0004_ffef;

    // Heartbeat periods, shortest legal value of each window
    localparam int unsigned CLK_KHZ       = 200000;
    localparam int unsigned HB_FAST_MS    = 1700;
    localparam int unsigned HB_SLOW_MS    = 7400;
    localparam logic [31:0] HB_FAST_CYC   = 32'(HB_FAST_MS * CLK_KHZ);
    localparam logic [31:0] HB_SLOW_CYC   = 32'(HB_SLOW_MS * CLK_KHZ);
    localparam logic [31:0] HB_CNT_ONE    = 32'h0000_0001;

endpackage
